// ==== rtl/fsr2_pkg.sv ====
package fsr2_pkg;

    // register placement and reset value
    localparam logic [7:0] FSR2_ADDR      = 8'h42;
    localparam logic [7:0] FSR2_RESET     = 8'h00;
    // bit positions
    localparam int         FSR2_B_V12VID     = 0;
    localparam int         FSR2_B_HOT        = 1;
    localparam int         FSR2_B_FAN_ONE    = 2;
    localparam int         FSR2_B_FAN_TWO    = 3;
    localparam int         FSR2_B_FAN_THREE  = 4;
    localparam int         FSR2_B_MULTI      = 5;
    localparam int         FSR2_B_DIODE_ONE  = 6;
    localparam int         FSR2_B_DIODE_TWO  = 7;
    // vid compare interval
    localparam int         FSR2_VID_NS    = 11000;
    localparam int         FSR2_CLK_NS    = 10;
    localparam int         FSR2_VID_CYC   = (FSR2_VID_NS + FSR2_CLK_NS - 1) / FSR2_CLK_NS;
    localparam int         FSR2_VID_W     = 6;
    localparam logic [10:0] FSR2_VID_LAST = 11'(FSR2_VID_CYC - 1);

    // multifunction pin modes
    typedef enum logic [1:0] {
        FSR2_PIN_TACH  = 2'b00,
        FSR2_PIN_GPIO  = 2'b01,
        FSR2_PIN_TIMER = 2'b11
    } fsr2_pin_mode_t;

    // fault conditions from the measurement logic
    typedef struct packed {
        logic       v12_out;
        logic       temp_over;
        logic       temp_below_hyst;
        logic [3:0] fan_slow;
        logic       thermal_limit_pin_time_over;
        logic [1:0] diode_fault;
    } fsr2_cond_t;

    // register access strobes
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fsr2_acc_t;

endpackage

// ==== rtl/fsr2_status.sv ====
`timescale 1ns/1ps
// Behaviour
// - bit 0 sets on 12 V limit fault; read clears only once it ends
// - in vid mode bit 0 sets when vid code differs from 11 us ago
// - vid change flag may drive the alert output when enabled
// - bit 1 sets when any channel exceeds its thermal_limit_pin limit
// - read clears bit 1 only when temperature below limit minus hysteresis
// - bits 2 to 4 set on fan one to three slow or stalled
// - fan one to three flags never set while their pwm is off
// - fourth tach mode: bit 5 sets when fan four is slow or stalled
// - fourth tach mode: fan four flag never sets while pwm three off
// - gpio mode: bit 5 writable and drives the pin level
// - timer mode: bit 5 sets when thermal_limit_pin time exceeds its limit
// - bit 6 sets on remote diode one open or short
// - bit 7 sets on remote diode two open or short
// - summary bit is the or of all flags here
// - register at address 0x42, resets to 0x00
module fsr2_status
    import fsr2_pkg::*;
(
    input  wire logic           mclk,
    input  wire logic           arst_n,
    input  wire fsr2_acc_t      acc,
    input  wire fsr2_cond_t     cond,
    input  wire logic [2:0]     pwm_off,
    input  wire fsr2_pin_mode_t pin_mode,
    input  wire logic           vid_mode,
    input  wire logic           vid_alert_en,
    input  wire logic [5:0]     vid_pins,
    output logic [7:0]          rdata,
    output logic                out_of_limit_summary,
    output logic                gpio_level,
    output logic                vid_alert
);
    logic [7:0] flag_ff;
    logic [7:0] nxt_flag;
    logic [7:0] set_v;
    logic [7:0] hold_v;
    logic [7:0] rdata_ff;
    logic       gpio_ff;
    logic [5:0] vid_s1_ff;
    logic [5:0] vid_s2_ff;
    logic       vid_change;
    logic       hit_rd;
    logic       hit_wr;
    logic       summary_ff;
    logic       alert_ff;

    // address match shared by read and write
    function automatic logic addr_hit(input logic [7:0] a);
        return a == FSR2_ADDR;
    endfunction

    assign hit_rd = acc.rd && addr_hit(acc.addr);
    assign hit_wr = acc.wr && addr_hit(acc.addr);

    // vid pins pass two flops
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            vid_s1_ff <= 6'h00;
            vid_s2_ff <= 6'h00;
        end else begin
            vid_s1_ff <= vid_pins;
            vid_s2_ff <= vid_s1_ff;
        end
    end

    fsr2_vid_watch #(
        .W (FSR2_VID_W)
    ) u_vid (
        .mclk       (mclk),
        .arst_n     (arst_n),
        .vid_sync   (vid_s2_ff),
        .vid_change (vid_change)
    );

    // set terms per flag
    always_comb begin
        set_v = 8'h00;
        set_v[FSR2_B_V12VID] = vid_mode ? vid_change : cond.v12_out;
        set_v[FSR2_B_HOT]       = cond.temp_over;
        set_v[FSR2_B_FAN_ONE]   = cond.fan_slow[0] && !pwm_off[0];
        set_v[FSR2_B_FAN_TWO]   = cond.fan_slow[1] && !pwm_off[1];
        set_v[FSR2_B_FAN_THREE] = cond.fan_slow[2] && !pwm_off[2];
        unique case (pin_mode)
            FSR2_PIN_TACH:  set_v[FSR2_B_MULTI] = cond.fan_slow[3] && !pwm_off[2];
            FSR2_PIN_TIMER: set_v[FSR2_B_MULTI] = cond.thermal_limit_pin_time_over;
            FSR2_PIN_GPIO:  set_v[FSR2_B_MULTI] = 1'b0;
            default:        set_v[FSR2_B_MULTI] = 1'b0;
        endcase
        set_v[FSR2_B_DIODE_ONE] = cond.diode_fault[0];
        set_v[FSR2_B_DIODE_TWO] = cond.diode_fault[1];
    end

    // conditions that block a read clear
    always_comb begin
        hold_v = set_v;
        hold_v[FSR2_B_HOT] = !cond.temp_below_hyst;
        // vid change is an event, nothing holds it
        if (vid_mode) hold_v[FSR2_B_V12VID] = 1'b0;
    end

    always_comb begin
        nxt_flag = flag_ff;
        if (hit_rd) nxt_flag = flag_ff & hold_v;
        nxt_flag = nxt_flag | set_v;
        if (pin_mode == FSR2_PIN_GPIO) nxt_flag[FSR2_B_MULTI] = 1'b0;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) flag_ff <= FSR2_RESET;
        else flag_ff <= nxt_flag;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) gpio_ff <= 1'b0;
        else if (hit_wr && pin_mode == FSR2_PIN_GPIO) gpio_ff <= acc.wdata[FSR2_B_MULTI];
    end

    // read data captured on the read strobe
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) rdata_ff <= 8'h00;
        else if (hit_rd) begin
            rdata_ff <= flag_ff;
            if (pin_mode == FSR2_PIN_GPIO) rdata_ff[FSR2_B_MULTI] <= gpio_ff;
        end
    end

    // summary flop follows the next flag value
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) summary_ff <= 1'b0;
        else summary_ff <= |nxt_flag;
    end

    // alert flop routed from the change flag
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) alert_ff <= 1'b0;
        else alert_ff <= vid_alert_en && vid_mode && nxt_flag[FSR2_B_V12VID];
    end

    assign rdata                = rdata_ff;
    assign gpio_level           = gpio_ff;
    assign out_of_limit_summary = summary_ff;
    assign vid_alert            = alert_ff;

    // no fan one flag set while pwm one off
    property p_fan_one_gate;
        @(posedge mclk) disable iff (!arst_n)
        (!flag_ff[FSR2_B_FAN_ONE] && pwm_off[0] && !hit_rd) |=> !flag_ff[FSR2_B_FAN_ONE];
    endproperty
    a_fan_one_gate: assert property (p_fan_one_gate) else $error("fan one flag set with pwm off");

    property p_sticky;
        @(posedge mclk) disable iff (!arst_n)
        (flag_ff[FSR2_B_DIODE_ONE] && !hit_rd) |=> flag_ff[FSR2_B_DIODE_ONE];
    endproperty
    a_sticky: assert property (p_sticky) else $error("diode flag dropped without read");

    property p_hold_on_read;
        @(posedge mclk) disable iff (!arst_n)
        (hit_rd && cond.diode_fault[1]) |=> flag_ff[FSR2_B_DIODE_TWO];
    endproperty
    a_hold_on_read: assert property (p_hold_on_read) else $error("active fault cleared by read");

    property p_hot_hyst;
        @(posedge mclk) disable iff (!arst_n)
        (flag_ff[FSR2_B_HOT] && hit_rd && !cond.temp_below_hyst) |=> flag_ff[FSR2_B_HOT];
    endproperty
    a_hot_hyst: assert property (p_hot_hyst) else $error("overtemp cleared above hysteresis");

    property p_hot_set;
        @(posedge mclk) disable iff (!arst_n)
        cond.temp_over |=> flag_ff[FSR2_B_HOT];
    endproperty
    a_hot_set: assert property (p_hot_set) else $error("overtemp flag not set");

    property p_summary;
        @(posedge mclk) disable iff (!arst_n)
        out_of_limit_summary == (flag_ff != 8'h00);
    endproperty
    a_summary: assert property (p_summary) else $error("summary mismatch");

    property p_tach_gate;
        @(posedge mclk) disable iff (!arst_n)
        (pin_mode == FSR2_PIN_TACH && cond.fan_slow[3] && !pwm_off[2]) |=> flag_ff[FSR2_B_MULTI];
    endproperty
    a_tach_gate: assert property (p_tach_gate) else $error("fan four flag not set");

    property p_tach_off;
        @(posedge mclk) disable iff (!arst_n)
        (pin_mode == FSR2_PIN_TACH && pwm_off[2] && !flag_ff[FSR2_B_MULTI]) |=> !flag_ff[FSR2_B_MULTI];
    endproperty
    a_tach_off: assert property (p_tach_off) else $error("fan four flag set with drive three off");

    property p_alert;
        @(posedge mclk) disable iff (!arst_n)
        (vid_alert_en && vid_mode && flag_ff[FSR2_B_V12VID] && !hit_rd) |=> vid_alert;
    endproperty
    a_alert: assert property (p_alert) else $error("change alert not raised");

    property p_alert_off;
        @(posedge mclk) disable iff (!arst_n)
        !vid_alert_en |=> !vid_alert;
    endproperty
    a_alert_off: assert property (p_alert_off) else $error("change alert raised while unrouted");

    property p_gpio;
        @(posedge mclk) disable iff (!arst_n)
        (hit_wr && pin_mode == FSR2_PIN_GPIO) |=> gpio_level == $past(acc.wdata[FSR2_B_MULTI]);
    endproperty
    a_gpio: assert property (p_gpio) else $error("gpio level not written");

    property p_timer;
        @(posedge mclk) disable iff (!arst_n)
        (pin_mode == FSR2_PIN_TIMER && cond.thermal_limit_pin_time_over) |=> flag_ff[FSR2_B_MULTI];
    endproperty
    a_timer: assert property (p_timer) else $error("thermal_limit_pin timer flag not set");

    property p_v12;
        @(posedge mclk) disable iff (!arst_n)
        (!vid_mode && cond.v12_out) |=> flag_ff[FSR2_B_V12VID];
    endproperty
    a_v12: assert property (p_v12) else $error("12 V flag not set");
endmodule // fsr2_status

// ==== rtl/fsr2_vid_watch.sv ====
`timescale 1ns/1ps
// flags a change of the voltage-id code against the value held one interval back
module fsr2_vid_watch
    import fsr2_pkg::*;
#(
    parameter int W = FSR2_VID_W
) (
    input  wire logic         mclk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] vid_sync,
    output logic              vid_change
);
    logic [10:0]  tick_ff;
    logic [W-1:0] ref_ff;
    logic         chg_ff;
    logic         primed_ff;

    // interval counter
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) tick_ff <= 11'h000;
        else if (tick_ff == FSR2_VID_LAST) tick_ff <= 11'h000;
        else tick_ff <= tick_ff + 11'h001;
    end

    // compare and resample at each interval end
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ref_ff    <= '0;
            chg_ff    <= 1'b0;
            primed_ff <= 1'b0;
        end else if (tick_ff == FSR2_VID_LAST) begin
            // first interval after reset only loads the reference, no false change
            chg_ff    <= primed_ff && (vid_sync != ref_ff);
            ref_ff    <= vid_sync;
            primed_ff <= 1'b1;
        end else begin
            chg_ff <= 1'b0;
        end
    end

    assign vid_change = chg_ff;
endmodule // fsr2_vid_watch

// ==== test/fsr2_host_model.sv ====
`timescale 1ns/1ps
// host side: issues one-cycle register strobes
module fsr2_host_model
    import fsr2_pkg::*;
(
    input  wire logic mclk,
    output fsr2_acc_t acc
);
    // idle bus at time zero
    initial acc = '0;

    // one access: raised after an edge, taken at the next, then released
    // read or write, chosen by r and w
    task automatic xfer(input logic r, input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1;
        acc = '{rd: r, wr: w, addr: a, wdata: d};
        @(posedge mclk);
        #1;
        acc = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d}; // stale values do not linger
    endtask
endmodule // fsr2_host_model

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    import fsr2_pkg::*;
    logic           mclk;
    logic           arst_n;
    fsr2_acc_t      acc;
    fsr2_cond_t     cond;
    logic [2:0]     pwm_off;
    fsr2_pin_mode_t pin_mode;
    logic           vid_mode;
    logic           vid_alert_en;
    logic [5:0]     vid_pins;
    logic [7:0]     rdata;
    logic           out_of_limit_summary;
    logic           gpio_level;
    logic           vid_alert;
    int             errors;
    int             n_checks;
    int             i;

    fsr2_host_model host (.mclk(mclk), .acc(acc));
    fsr2_status DUT (.mclk(mclk), .arst_n(arst_n), .acc(acc), .cond(cond), .pwm_off(pwm_off),
        .pin_mode(pin_mode), .vid_mode(vid_mode), .vid_alert_en(vid_alert_en), .vid_pins(vid_pins),
        .rdata(rdata), .out_of_limit_summary(out_of_limit_summary), .gpio_level(gpio_level),
        .vid_alert(vid_alert));

    // clock
    initial mclk = 1'b0;
    always #5 mclk = ~mclk;

    // verdict and end of run
    task automatic report_and_stop();
        if (errors == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // compare seen against expected
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // advance n edges, land just after the last
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // read one address and compare
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        host.xfer(1'b1, 1'b0, a, 8'h00);
        check(rdata, exp);
    endtask

    // fault cause for one bit; 8 gives the quiet state
    function automatic fsr2_cond_t cause(input int b);
        fsr2_cond_t c;
        c = '0;
        c.temp_below_hyst = 1'b1;
        case (b)
            0: c.v12_out = 1'b1;
            1: begin
                c.temp_over = 1'b1;
                c.temp_below_hyst = 1'b0;
            end
            2, 3, 4, 5: c.fan_slow[b-2] = 1'b1;
            6, 7: c.diode_fault[b-6] = 1'b1;
            default: c.v12_out = 1'b0;
        endcase
        return c;
    endfunction

    // main sequence
    initial begin
        errors = 0;
        n_checks = 0;
        arst_n = 1'b0;
        cond = cause(8);
        pwm_off = 3'h0;
        pin_mode = FSR2_PIN_TACH;
        vid_mode = 1'b0;
        vid_alert_en = 1'b0;
        vid_pins = 6'h00;
        repeat (4) @(posedge mclk);
        #1;
        arst_n = 1'b1;
        rd_chk(FSR2_ADDR, FSR2_RESET);
        for (i = 0; i < 8; i++) begin
            cond = cause(i);
            tick(2);
            check({7'h00, out_of_limit_summary}, 8'h01);
            rd_chk(FSR2_ADDR, 8'h01 << i);
            cond = cause(8);
            tick(1);
            rd_chk(FSR2_ADDR, 8'h01 << i);
            rd_chk(FSR2_ADDR, 8'h00);
            check({7'h00, out_of_limit_summary}, 8'h00);
        end
        // over limit, then cooled but not below hysteresis
        cond = cause(1);
        tick(2);
        cond.temp_over = 1'b0;
        rd_chk(FSR2_ADDR, 8'h02);
        rd_chk(FSR2_ADDR, 8'h02);
        cond = cause(8);
        rd_chk(FSR2_ADDR, 8'h02);
        rd_chk(FSR2_ADDR, 8'h00);
        // stalled fans with drives off
        pwm_off = 3'h7;
        cond.fan_slow = 4'hf;
        tick(3);
        rd_chk(FSR2_ADDR, 8'h00);
        // each drive gates only its own fan, drive three also gates fan four
        pwm_off = 3'h5;
        tick(2);
        rd_chk(FSR2_ADDR, 8'h08);
        pwm_off = 3'h2;
        tick(2);
        cond = cause(8);
        rd_chk(FSR2_ADDR, 8'h3c);
        pwm_off = 3'h0;
        rd_chk(FSR2_ADDR, 8'h00);
        // foreign address leaves flags and read data alone
        cond = cause(7);
        tick(2);
        cond = cause(8);
        rd_chk(8'h43, 8'h00);
        rd_chk(FSR2_ADDR, 8'h80);
        rd_chk(FSR2_ADDR, 8'h00);
        // reset in mid-run drops a set flag
        cond = cause(6);
        tick(2);
        cond = cause(8);
        arst_n = 1'b0;
        tick(2);
        arst_n = 1'b1;
        check({7'h00, out_of_limit_summary}, 8'h00);
        rd_chk(FSR2_ADDR, FSR2_RESET);
        // timer mode
        pin_mode = FSR2_PIN_TIMER;
        cond.thermal_limit_pin_time_over = 1'b1;
        tick(2);
        cond = cause(8);
        rd_chk(FSR2_ADDR, 8'h20);
        rd_chk(FSR2_ADDR, 8'h00);
        // gpio mode
        pin_mode = FSR2_PIN_GPIO;
        host.xfer(1'b0, 1'b1, FSR2_ADDR, 8'h20);
        tick(1);
        check({7'h00, gpio_level}, 8'h01);
        rd_chk(FSR2_ADDR, 8'h20);
        host.xfer(1'b0, 1'b1, 8'h41, 8'h00);
        tick(1);
        check({7'h00, gpio_level}, 8'h01);
        // writes outside gpio mode leave the pin alone
        pin_mode = FSR2_PIN_TIMER;
        host.xfer(1'b0, 1'b1, FSR2_ADDR, 8'h00);
        tick(1);
        check({7'h00, gpio_level}, 8'h01);
        // fan four stall never reaches bit 5 in gpio mode
        pin_mode = FSR2_PIN_GPIO;
        cond.fan_slow[3] = 1'b1;
        host.xfer(1'b0, 1'b1, FSR2_ADDR, 8'h00);
        tick(1);
        check({7'h00, gpio_level}, 8'h00);
        cond = cause(8);
        rd_chk(FSR2_ADDR, 8'h00);
        // vid change detection, 12 V fault is no source in this mode
        pin_mode = FSR2_PIN_TACH;
        vid_mode = 1'b1;
        vid_alert_en = 1'b1;
        cond = cause(0);
        tick(2 * FSR2_VID_CYC);
        cond = cause(8);
        rd_chk(FSR2_ADDR, 8'h00);
        vid_pins = 6'h2a;
        for (i = 0; i < 3 * FSR2_VID_CYC && vid_alert !== 1'b1; i++) tick(1);
        check({7'h00, vid_alert}, 8'h01);
        if (vid_alert === 1'b1) begin
            rd_chk(FSR2_ADDR, 8'h01);
            rd_chk(FSR2_ADDR, 8'h00);
            // change still flagged with the alert unrouted
            vid_alert_en = 1'b0;
            vid_pins = 6'h15;
            tick(3 * FSR2_VID_CYC);
            check({7'h00, vid_alert}, 8'h00);
            rd_chk(FSR2_ADDR, 8'h01);
            rd_chk(FSR2_ADDR, 8'h00);
        end
        report_and_stop();
    end
endmodule // tb_top
